// *** hdl/iqg_map.vh ***
`ifndef IQG_MAP_VH
`define IQG_MAP_VH
// ============================================================
// Address map
`define IQG_OFS_INCTL 12'h000
`define IQG_PAIR_BLK 7'h08
`define IQG_PORT_BLK 7'h10
`define IQG_PR_CTL 5'h00
`define IQG_PR_DCI 5'h04
`define IQG_PR_DCQ 5'h08
`define IQG_PR_PHS 5'h0c
`define IQG_PR_AMP 5'h10
`define IQG_PT_GAIN 5'h00
`define IQG_PT_DWELL 5'h04
`define IQG_PT_PER 5'h08
`define IQG_PT_RES 5'h0c
`define IQG_PT_UPTH 5'h10
`define IQG_PT_LOTH 5'h14
`define IQG_PT_SMON 5'h18
// ============================================================
// Fields
`define IQG_CPLX_LSB 24
`define IQG_AMP_BW 15:12
`define IQG_PHS_BW 11:8
`define IQG_DC_BW 7:4
`define IQG_RSVD 3
`define IQG_AMP_AUTO 2
`define IQG_PHS_AUTO 1
`define IQG_DC_AUTO 0
`define IQG_RELIN 6:1
`define IQG_GAIN_EN 0
`define IQG_MON_EN 0
`define IQG_MON_MODE 2:1
`define IQG_MON_CLR 3
`define IQG_MON_NOTMR 4
`define IQG_MODE_PEAK 2'h0
`define IQG_MODE_MEAN 2'h1
`define IQG_MODE_THR 2'h2
// ============================================================
// Reset values and counts
`define IQG_RST_BIT 1'b0
`define IQG_DEC_MIN 5'h0c
`define IQG_BW_MAX 4'hb
`define IQG_EXP_MAX 3'h7
`endif

// *** hdl/iqg_input_cond.v ***
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "iqg_map.vh"
module iqg_input_cond (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [63:0] adc_data,
   input wire [11:0] gain_exponent_lines_i,
   output wire [11:0] gain_exponent_lines_o,
   output wire [11:0] gain_exponent_lines_oe,
   output wire [63:0] port_data,
   output wire [11:0] relin_exp
);
   // ============================================================
   // Helpers
   function [4:0] dec_shift;
      input [3:0] bw;
      begin
         dec_shift = `IQG_DEC_MIN + ((bw > `IQG_BW_MAX) ? {1'b0, `IQG_BW_MAX}
                                                        : {1'b0, bw});
      end
   endfunction
   function [15:0] mag16;
      input [15:0] v;
      begin
         mag16 = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   // ============================================================
   // Pin synchronisers
   reg [63:0] adc_s1_q, adc_s2_q;
   reg [11:0] exp_s1_q, exp_s2_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_s1_q <= {64{`IQG_RST_BIT}};
         adc_s2_q <= {64{`IQG_RST_BIT}};
         exp_s1_q <= {12{`IQG_RST_BIT}};
         exp_s2_q <= {12{`IQG_RST_BIT}};
      end else begin
         adc_s1_q <= adc_data;
         adc_s2_q <= adc_s1_q;
         exp_s1_q <= gain_exponent_lines_i;
         exp_s2_q <= exp_s1_q;
      end
   end

   // ============================================================
   // APB slave, no wait states
   wire acc = psel & penable & pready;
   wire apb_wr = acc & pwrite;
   wire apb_rd = acc & ~pwrite;
   reg [1:0] cplx_q;
   wire [63:0] pair_rv;
   wire [1:0] pair_hit;
   wire [127:0] port_rv;
   wire [3:0] port_hit;
   reg [31:0] rd_d;
   reg hit_d;
   integer r;
   always @* begin
      rd_d = 32'h00000000;
      hit_d = (paddr == `IQG_OFS_INCTL);
      if (hit_d)
         rd_d[`IQG_CPLX_LSB+1:`IQG_CPLX_LSB] = cplx_q;
      for (r = 0; r < 2; r = r + 1) begin
         rd_d = rd_d | pair_rv[r*32 +: 32];
         hit_d = hit_d | pair_hit[r];
      end
      for (r = 0; r < 4; r = r + 1) begin
         rd_d = rd_d | port_rv[r*32 +: 32];
         hit_d = hit_d | port_hit[r];
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         cplx_q <= 2'h0;
      end else begin
         // Setup cycle samples the answer, access cycle shows it
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr <= ~hit_d;
            prdata <= pwrite ? 32'h00000000 : rd_d;
         end
         if (apb_wr && paddr == `IQG_OFS_INCTL)
            cplx_q <= pwdata[`IQG_CPLX_LSB+1:`IQG_CPLX_LSB];
      end
   end

   // ============================================================
   // I/Q correction, one block per port pair
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_pair
         localparam integer BLKN = `IQG_PAIR_BLK + p;
         localparam [6:0] BLK = BLKN[6:0];
         reg [15:0] ctl_q, dci_q, dcq_q, phs_q, amp_q;
         reg signed [39:0] acc_di_q, acc_dq_q;
         reg signed [47:0] acc_ph_q, acc_am_q;
         reg [15:0] out_i_q, out_q_q;
         wire cplx = cplx_q[p];
         wire signed [15:0] xi = adc_s2_q[p*32 +: 16];
         wire signed [15:0] xq = adc_s2_q[p*32+16 +: 16];
         wire [4:0] k_dc = dec_shift(ctl_q[`IQG_DC_BW]);
         wire [4:0] k_ph = dec_shift(ctl_q[`IQG_PHS_BW]);
         wire [4:0] k_am = dec_shift(ctl_q[`IQG_AMP_BW]);
         wire signed [39:0] e_di = acc_di_q >>> k_dc;
         wire signed [39:0] e_dq = acc_dq_q >>> k_dc;
         wire signed [47:0] e_ph = acc_ph_q >>> k_ph;
         wire signed [47:0] e_am = acc_am_q >>> k_am;
         // Manual values come from software when automatic is off
         wire signed [15:0] dc_i = ctl_q[`IQG_DC_AUTO] ? e_di[15:0] : dci_q;
         wire signed [15:0] dc_q = ctl_q[`IQG_DC_AUTO] ? e_dq[15:0] : dcq_q;
         wire signed [13:0] ph_c = ctl_q[`IQG_PHS_AUTO] ? e_ph[13:0]
                                                        : phs_q[13:0];
         wire signed [13:0] am_c = ctl_q[`IQG_AMP_AUTO] ? e_am[13:0]
                                                        : amp_q[13:0];
         wire signed [15:0] i1 = xi - dc_i;
         wire signed [15:0] q1 = xq - dc_q;
         wire signed [29:0] pp = ph_c * q1;
         wire signed [29:0] ap = am_c * q1;
         wire signed [15:0] i2 = i1 + pp[28:13];
         wire signed [15:0] q2 = q1 + ap[28:13];
         wire signed [31:0] iq = i2 * q2;
         wire signed [16:0] aerr = {1'b0, mag16(i2)} - {1'b0, mag16(q2)};
         reg [31:0] rv;
         always @* begin
            rv = 32'h00000000;
            if (paddr[11:5] == BLK) begin
               case (paddr[4:0])
                  `IQG_PR_CTL: rv[15:0] = ctl_q;
                  `IQG_PR_DCI: rv[15:0] = dci_q;
                  `IQG_PR_DCQ: rv[15:0] = dcq_q;
                  `IQG_PR_PHS: rv[15:0] = phs_q;
                  `IQG_PR_AMP: rv[15:0] = amp_q;
                  default: rv = 32'h00000000;
               endcase
            end
         end
         assign pair_rv[p*32 +: 32] = rv;
         assign pair_hit[p] = (paddr[11:5] == BLK) &&
            (paddr[4:0] == `IQG_PR_CTL || paddr[4:0] == `IQG_PR_DCI ||
             paddr[4:0] == `IQG_PR_DCQ || paddr[4:0] == `IQG_PR_PHS ||
             paddr[4:0] == `IQG_PR_AMP);
         assign port_data[p*32 +: 32] = {out_q_q, out_i_q};
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctl_q <= {16{`IQG_RST_BIT}};
               dci_q <= {16{`IQG_RST_BIT}};
               dcq_q <= {16{`IQG_RST_BIT}};
               phs_q <= {16{`IQG_RST_BIT}};
               amp_q <= {16{`IQG_RST_BIT}};
               acc_di_q <= {40{`IQG_RST_BIT}};
               acc_dq_q <= {40{`IQG_RST_BIT}};
               acc_ph_q <= {48{`IQG_RST_BIT}};
               acc_am_q <= {48{`IQG_RST_BIT}};
               out_i_q <= {16{`IQG_RST_BIT}};
               out_q_q <= {16{`IQG_RST_BIT}};
            end else begin
               if (apb_wr && paddr[11:5] == BLK) begin
                  case (paddr[4:0])
                     `IQG_PR_CTL: begin
                        ctl_q <= pwdata[15:0];
                        ctl_q[`IQG_RSVD] <= 1'b0;
                     end
                     `IQG_PR_DCI: dci_q <= pwdata[15:0];
                     `IQG_PR_DCQ: dcq_q <= pwdata[15:0];
                     `IQG_PR_PHS: phs_q <= pwdata[15:0];
                     `IQG_PR_AMP: amp_q <= pwdata[15:0];
                     default: ctl_q <= ctl_q;
                  endcase
               end
               if (cplx) begin
                  // DC loops are leaky integrators with time constant equal to the decimation; phase and amplitude loops integrate without leak
                  acc_di_q <= acc_di_q + {{24{xi[15]}}, xi} - e_di;
                  acc_dq_q <= acc_dq_q + {{24{xq[15]}}, xq} - e_dq;
                  acc_ph_q <= acc_ph_q - {{32{iq[31]}}, iq[31:16]};
                  acc_am_q <= acc_am_q + {{31{aerr[16]}}, aerr};
                  out_i_q <= i2;
                  out_q_q <= q2;
               end else begin
                  // Real mode: enable bits and correction values unused
                  acc_di_q <= {40{`IQG_RST_BIT}};
                  acc_dq_q <= {40{`IQG_RST_BIT}};
                  acc_ph_q <= {48{`IQG_RST_BIT}};
                  acc_am_q <= {48{`IQG_RST_BIT}};
                  out_i_q <= xi;
                  out_q_q <= xq;
               end
            end
         end
      end
   endgenerate

   // ============================================================
   // Gain control and power monitor, one block per port
   genvar n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_port
         localparam integer BLKN = `IQG_PORT_BLK + n;
         localparam [6:0] BLK = BLKN[6:0];
         reg [7:0] gain_q;
         reg [19:0] dwell_q, dcnt_q;
         reg [23:0] per_q, res_q, pcnt_q, macc_q;
         reg [9:0] upth_q, loth_q;
         reg [4:0] smon_q;
         reg [2:0] exp_q, rexp_q;
         reg drun_q, below_q;
         reg [5:0] wp_q;
         reg [2:0] dl [0:63];
         wire [15:0] mag = mag16(adc_s2_q[n*16 +: 16]);
         wire over = mag[15:6] > upth_q;
         wire below = mag[15:6] < loth_q;
         wire [31:0] sq = mag * mag;
         wire [24:0] msum = {1'b0, macc_q} + {9'h000, sq[31:16]};
         wire [2:0] exp_src = gain_q[`IQG_GAIN_EN] ? exp_q
                                                   : exp_s2_q[n*3 +: 3];
         wire [5:0] dly = gain_q[`IQG_RELIN];
         wire pend = (pcnt_q == 24'h000000);
         wire res_sel = apb_rd && paddr[11:5] == BLK &&
                        paddr[4:0] == `IQG_PT_RES;
         reg [23:0] mnext;
         reg [31:0] rv;
         integer k;
         always @* begin
            mnext = macc_q;
            case (smon_q[`IQG_MON_MODE])
               `IQG_MODE_PEAK:
                  if (over && {8'h00, mag} > macc_q)
                     mnext = {8'h00, mag};
               `IQG_MODE_MEAN:
                  mnext = msum[24] ? 24'hffffff : msum[23:0];
               `IQG_MODE_THR:
                  if (over && macc_q != 24'hffffff)
                     mnext = macc_q + 24'h000001;
               default: mnext = macc_q; // Invalid selection holds
            endcase
         end
         always @* begin
            rv = 32'h00000000;
            if (paddr[11:5] == BLK) begin
               case (paddr[4:0])
                  `IQG_PT_GAIN: rv[7:0] = {1'b0, gain_q[6:0]};
                  `IQG_PT_DWELL: rv[19:0] = dwell_q;
                  `IQG_PT_PER: rv[23:0] = per_q;
                  `IQG_PT_RES: rv[23:0] = smon_q[`IQG_MON_NOTMR] ? macc_q
                                                                 : res_q;
                  `IQG_PT_UPTH: rv[9:0] = upth_q;
                  `IQG_PT_LOTH: rv[9:0] = loth_q;
                  `IQG_PT_SMON: rv[4:0] = smon_q;
                  default: rv = 32'h00000000;
               endcase
            end
         end
         assign port_rv[n*32 +: 32] = rv;
         assign port_hit[n] = (paddr[11:5] == BLK) &&
                              (paddr[4:0] <= `IQG_PT_SMON) &&
                              (paddr[1:0] == 2'h0);
         assign gain_exponent_lines_o[n*3 +: 3] = exp_q;
         assign gain_exponent_lines_oe[n*3 +: 3] =
            {3{gain_q[`IQG_GAIN_EN]}};
         assign relin_exp[n*3 +: 3] = rexp_q;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               gain_q <= {8{`IQG_RST_BIT}};
               dwell_q <= {20{`IQG_RST_BIT}};
               dcnt_q <= {20{`IQG_RST_BIT}};
               per_q <= {24{`IQG_RST_BIT}};
               res_q <= {24{`IQG_RST_BIT}};
               pcnt_q <= {24{`IQG_RST_BIT}};
               macc_q <= {24{`IQG_RST_BIT}};
               upth_q <= {10{`IQG_RST_BIT}};
               loth_q <= {10{`IQG_RST_BIT}};
               smon_q <= {5{`IQG_RST_BIT}};
               exp_q <= 3'h0;
               rexp_q <= 3'h0;
               drun_q <= 1'b0;
               below_q <= 1'b0;
               wp_q <= 6'h00;
               for (k = 0; k < 64; k = k + 1)
                  dl[k] <= 3'h0;
            end else begin
               if (apb_wr && paddr[11:5] == BLK) begin
                  case (paddr[4:0])
                     `IQG_PT_GAIN: gain_q <= {1'b0, pwdata[6:0]};
                     `IQG_PT_DWELL: dwell_q <= pwdata[19:0];
                     `IQG_PT_PER: per_q <= pwdata[23:0];
                     `IQG_PT_UPTH: upth_q <= pwdata[9:0];
                     `IQG_PT_LOTH: loth_q <= pwdata[9:0];
                     `IQG_PT_SMON: smon_q <= pwdata[4:0];
                     default: gain_q <= gain_q;
                  endcase
               end
               // Gain stepping; exponent saturates at both ends
               below_q <= below;
               if (gain_q[`IQG_GAIN_EN]) begin
                  if (over) begin
                     if (exp_q != `IQG_EXP_MAX)
                        exp_q <= exp_q + 3'h1;
                     drun_q <= 1'b0;
                  end else if (below && !below_q) begin
                     dcnt_q <= dwell_q;
                     drun_q <= 1'b1;
                  end else if (drun_q) begin
                     if (dcnt_q == 20'h00000) begin
                        drun_q <= 1'b0;
                        if (exp_q != 3'h0)
                           exp_q <= exp_q - 3'h1;
                     end else begin
                        dcnt_q <= dcnt_q - 20'h00001;
                     end
                  end
               end else begin
                  drun_q <= 1'b0;
               end
               // Relinearization delay line, 64 deep
               dl[wp_q] <= exp_src;
               wp_q <= wp_q + 6'h01;
               rexp_q <= (dly == 6'h00) ? exp_src : dl[wp_q - dly];
               // Power monitor
               if (!smon_q[`IQG_MON_EN]) begin
                  macc_q <= {24{`IQG_RST_BIT}};
                  pcnt_q <= (per_q == 24'h000000) ? 24'h000000
                                                 : per_q - 24'h000001;
               end else if (smon_q[`IQG_MON_NOTMR]) begin
                  // Timer off: a read of the result takes the snapshot
                  macc_q <= (res_sel && smon_q[`IQG_MON_CLR]) ? 24'h000000
                                                              : mnext;
                  if (res_sel)
                     res_q <= macc_q;
               end else if (pend) begin
                  res_q <= mnext;
                  macc_q <= {24{`IQG_RST_BIT}};
                  pcnt_q <= (per_q == 24'h000000) ? 24'h000000
                                                 : per_q - 24'h000001;
               end else begin
                  macc_q <= mnext;
                  pcnt_q <= pcnt_q - 24'h000001;
               end
            end
         end
      end
   endgenerate
endmodule // iqg_input_cond

// *** tb/iqg_adc_model.sv ***
`timescale 1ns/1ps
// ============================================
// ADC model: registered samples and exponent
module iqg_adc_model (
   input wire pclk,
   input wire presetn,
   input wire [63:0] smp_set,
   input wire [11:0] exp_set,
   input wire [11:0] dev_oe,
   output reg [63:0] adc_data,
   output reg [11:0] exp_drv,
   output wire [11:0] exp_drv_en
);
   // Lets go of every line the device drives
   assign exp_drv_en = ~dev_oe;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_data <= 64'h0;
         exp_drv <= 12'h0;
      end else begin
         adc_data <= smp_set;
         exp_drv <= exp_set;
      end
   end
endmodule // iqg_adc_model

// *** tb/iqg_checker_properties.sv ***
`timescale 1ns/1ps
// ============================================
// Port checker
module iqg_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [63:0] adc_data,
   input wire [11:0] gain_exponent_lines_i,
   input wire [11:0] gain_exponent_lines_o,
   input wire [11:0] gain_exponent_lines_oe,
   input wire [63:0] port_data,
   input wire [11:0] relin_exp
);
   reg [1:0] cplx_q;
   reg [2:0] calm_q;
   reg gen_q;
   wire wr = psel && penable && pready && pwrite;
   wire rd = psel && penable && pready && !pwrite;
   // Pass-through judged only once the mode has settled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cplx_q <= 2'h0;
         calm_q <= 3'h0;
         gen_q <= 1'b0;
      end else begin
         if (wr && paddr == 12'h000) begin
            cplx_q <= pwdata[25:24];
            calm_q <= 3'h0;
         end else if (calm_q != 3'h7) begin
            calm_q <= calm_q + 3'h1;
         end
         if (wr && paddr == 12'h200) begin
            gen_q <= pwdata[0];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_APB_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   AST_APB_SINGLE: assert property (pready |-> $past(psel && !penable))
      else $error("answer without setup");
   AST_ERR_ZERO: assert property (rd && pslverr |-> prdata == 32'h0)
      else $error("refused read not zero");
   AST_CTL_RSVD: assert property (
      rd && paddr[11:6] == 6'h04 && paddr[4:0] == 5'h00
      |-> prdata[31:16] == 16'h0 && !prdata[3])
      else $error("reserved control bit set");
   AST_UPTH_WIDE: assert property (
      rd && paddr[11:8] == 4'h2 && paddr[4:0] == 5'h10
      |-> prdata[31:10] == 22'h0)
      else $error("upper threshold too wide");
   AST_RES_WIDE: assert property (
      rd && paddr[11:8] == 4'h2 && paddr[4:0] == 5'h0c
      |-> prdata[31:24] == 8'h0)
      else $error("monitor result too wide");
   AST_EXP_DIR: assert property (
      gen_q == $past(gen_q) |-> gain_exponent_lines_oe[2:0] == {3{gen_q}})
      else $error("exponent direction wrong");
   AST_REAL_AB: assert property (
      calm_q == 3'h7 && !cplx_q[0]
      |-> port_data[31:0] == $past(adc_data[31:0], 3))
      else $error("real pair AB altered");
   AST_REAL_CD: assert property (
      calm_q == 3'h7 && !cplx_q[1]
      |-> port_data[63:32] == $past(adc_data[63:32], 3))
      else $error("real pair CD altered");
endmodule // iqg_checker
bind iqg_input_cond iqg_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .adc_data(adc_data), .gain_exponent_lines_i(gain_exponent_lines_i),
   .gain_exponent_lines_o(gain_exponent_lines_o),
   .gain_exponent_lines_oe(gain_exponent_lines_oe),
   .port_data(port_data), .relin_exp(relin_exp));

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ============================================
// Bench
module tb;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
   logic [11:0] paddr = 12'h0, exp_set = 12'h0, b;
   logic [31:0] pwdata = 32'h0, rdata, ex;
   logic [63:0] smp = 64'h0;
   logic [15:0] mg, sv;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [63:0] adc_data, port_data;
   wire [11:0] exi, exo, exoe, relin, exd, exd_en;
   int failures = 0, checks_done = 0, cyc = 0, n, per;
   logic [11:0] ta [0:6] = '{12'h100, 12'h120, 12'h104, 12'h210, 12'h204,
      12'h208, 12'h20c};
   logic [31:0] te [0:6] = '{32'hfff7, 32'hfff7, 32'hffff, 32'h3ff,
      32'hfffff, 32'hffffff, 32'h0};
   assign exi = (exoe & exo) | (exd_en & exd);
   always #50 pclk = ~pclk;
   iqg_input_cond DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_data(adc_data), .gain_exponent_lines_i(exi),
      .gain_exponent_lines_o(exo), .gain_exponent_lines_oe(exoe),
      .port_data(port_data), .relin_exp(relin));
   iqg_adc_model u_adc (.pclk(pclk), .presetn(presetn), .smp_set(smp),
      .exp_set(exp_set), .dev_oe(exoe), .adc_data(adc_data),
      .exp_drv(exd), .exp_drv_en(exd_en));
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdata);
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         test_done;
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, ta[i], 32'hffffffff);
         rdc(ta[i], te[i]);
      end
      rdc(12'h0f0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      $display("test registers done");
      smp <= 64'h8001_7fff_0123_fedc;
      repeat (6) @(posedge pclk);
      chk("real ab", 32'h0123fedc, port_data[31:0]);
      chk("real cd", 32'h80017fff, port_data[63:32]);
      apb(1'b1, 12'h000, 32'h03000000);
      smp <= 64'h0200_1000_0200_1000;
      for (int p = 0; p < 2; p++) begin
         b = 12'h100 + 12'(32 * p);
         apb(1'b1, b, 32'h0);
         apb(1'b1, b + 12'h4, 32'h10);
         apb(1'b1, b + 12'h8, 32'h20);
         apb(1'b1, b + 12'hc, 32'h0);
         apb(1'b1, b + 12'h10, 32'h0);
         repeat (6) @(posedge pclk);
         chk("dc", 32'h01e00ff0, port_data[32*p +: 32]);
         apb(1'b1, b + 12'h4, 32'h0);
         apb(1'b1, b + 12'h8, 32'h0);
         apb(1'b1, b + 12'hc, 32'h1000);
         repeat (6) @(posedge pclk);
         chk("phase", 32'h02001100, port_data[32*p +: 32]);
         apb(1'b1, b + 12'hc, 32'h0);
         apb(1'b1, b + 12'h10, 32'h1000);
         repeat (6) @(posedge pclk);
         chk("amplitude", 32'h03001000, port_data[32*p +: 32]);
      end
      apb(1'b1, 12'h000, 32'h0);
      $display("test correction done");
      for (int q = 0; q < 4; q++) begin
         apb(1'b1, 12'h200 + 12'(32 * q), 32'h1);
         repeat (2) @(posedge pclk);
         chk("oe", 32'h7 << (3 * q), {20'h0, exoe});
         apb(1'b1, 12'h200 + 12'(32 * q), 32'h0);
      end
      for (int d = 0; d < 6; d += 5) begin
         apb(1'b1, 12'h200, 32'(d * 2));
         exp_set <= 12'h0;
         repeat (12) @(posedge pclk);
         exp_set <= 12'h5;
         n = 0;
         while (relin[2:0] !== 3'h5 && n < 40) begin
            @(posedge pclk);
            n++;
         end
         chk("relin delay", 32'(d + 5), 32'(n));
      end
      apb(1'b1, 12'h210, 32'h10);
      apb(1'b1, 12'h214, 32'h4);
      apb(1'b1, 12'h204, 32'd20);
      apb(1'b1, 12'h200, 32'h1);
      smp <= {4{16'hf000}};
      repeat (30) @(posedge pclk);
      chk("exp raise", 32'h7, {29'h0, exo[2:0]});
      smp <= {4{16'h0200}};
      repeat (40) @(posedge pclk);
      chk("exp hold", 32'h7, {29'h0, exo[2:0]});
      smp <= {4{16'h0040}};
      n = 0;
      while (exo[2:0] === 3'h7 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      chk("dwell", 32'h1, {31'h0, n >= 20 && n <= 28});
      apb(1'b1, 12'h200, 32'h0);
      $display("test gain done");
      for (int q = 0; q < 4; q += 3) for (int k = 0; k < 2; k++)
         for (int m = 0; m < 4; m++) for (int s = 0; s < 3; s++) begin
            b = 12'h200 + 12'(32 * q);
            per = 8 << k;
            mg = (s == 2) ? 16'h0200 : 16'h1000;
            sv = (s == 1) ? 16'hf000 : mg;
            apb(1'b1, b + 12'h8, 32'(per));
            apb(1'b1, b + 12'h10, 32'h10);
            apb(1'b1, b + 12'h18, 32'(m * 2 + 1));
            smp <= {4{sv}};
            repeat (3 * per + 8) @(posedge pclk);
            ex = (m == 2) ? 32'((s == 2) ? 0 : per)
               : (m == 0) ? ((s == 2) ? 32'h0 : 32'h1000)
               : (m == 3) ? 32'h0
               : 32'(((32'(mg) * mg) >> 16) * per);
            rdc(b + 12'hc, ex);
         end
      // Timer off: peak held across reads, cleared by a read
      smp <= {4{16'h1000}};
      apb(1'b1, 12'h278, 32'h11);
      repeat (8) @(posedge pclk);
      rdc(12'h26c, 32'h1000);
      smp <= {4{16'h0200}};
      repeat (8) @(posedge pclk);
      rdc(12'h26c, 32'h1000);
      apb(1'b1, 12'h278, 32'h19);
      rdc(12'h26c, 32'h1000);
      rdc(12'h26c, 32'h0);
      $display("test monitor done");
      test_done;
   end
endmodule // tb
